// ===== dv/dtr_bank_test.sv
// Self-checking bench for the converter trim and interrupt status bank
`timescale 1ns/1ps
`default_nettype none
module dtr_bank_test
    import dtr_pkg::*;
;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rexp;
    } dtr_row_t;

    localparam dtr_row_t ROWS [9] = '{
        '{5'h06, 16'hFFFF, 16'hE3FF},
        '{5'h07, 16'hFFFF, 16'hC3FF},
        '{5'h08, 16'h1C00, 16'h0000},
        '{5'h08, 16'hA155, 16'hA155},
        '{5'h06, 16'h4AAA, 16'h42AA},
        '{5'h07, 16'h3C01, 16'h0001},
        '{5'h05, 16'hFFFF, 16'h0000},
        '{5'h0A, 16'hFFFF, 16'h0000},
        '{5'h09, 16'h0003, 16'h0003}
    };

    logic              clk;
    logic              rst_n;
    dtr_req_t          req;
    dtr_evt_t          evt;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    dtr_aux_t          aux1_ctl;
    dtr_aux_t          aux2_ctl;
    dtr_qch_t          qch_ctl;
    logic              irq_n;
    logic [DATA_W-1:0] sh [3];
    int                n_errors;
    int                n_checks;
    int                cycles;

    dtr_bank i_dut (
        .clk      (clk),
        .rst_n    (rst_n),
        .req      (req),
        .rdata    (rdata),
        .rvalid   (rvalid),
        .evt      (evt),
        .aux1_ctl (aux1_ctl),
        .aux2_ctl (aux2_ctl),
        .qch_ctl  (qch_ctl),
        .irq_n    (irq_n)
    );

    dtr_host i_host (
        .clk    (clk),
        .req    (req),
        .rdata  (rdata),
        .rvalid (rvalid)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        logic              v;
        i_host.rd(a, d, v);
        chk({15'h0, v}, 16'h0001);
        chk(d, exp);
    endtask

    // Converter outputs against the shadow copies
    task automatic out_chk();
        chk({3'h0, aux1_ctl}, {3'h0, sh[0][15:13], sh[0][9:0]});
        chk({4'h0, qch_ctl}, {4'h0, sh[1][15:14], sh[1][9:0]});
        chk({3'h0, aux2_ctl}, {3'h0, sh[2][15:13], sh[2][9:0]});
    endtask

    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        sh = '{16'h0000, 16'h0000, 16'h0000};
    endtask

    task automatic pulse(input logic data, input logic sync);
        @(negedge clk);
        evt.data_err = data;
        evt.sync_err = sync;
        @(negedge clk);
        evt.data_err = 1'b0;
        evt.sync_err = 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_errors++;
            conclude();
        end
    end

    initial
    begin
        rst_n = 1'b0;
        evt = '0;
        n_errors = 0;
        n_checks = 0;
        cycles = 0;
        do_reset();
        foreach (ROWS[i])
        begin
            i_host.wr(ROWS[i].addr, ROWS[i].wdata);
            if (ROWS[i].addr >= 5'h06 && ROWS[i].addr <= 5'h08)
                sh[ROWS[i].addr - 5'h06] = ROWS[i].rexp;
            rd_chk(ROWS[i].addr, ROWS[i].rexp);
            out_chk();
        end
        // Mid-run reset returns every register to zero
        do_reset();
        out_chk();
        chk({15'h0, irq_n}, 16'h0001);
        for (int a = 6; a <= 9; a++)
            rd_chk(5'(a), 16'h0000);
        // Masked data error is dropped
        pulse(1'b1, 1'b0);
        repeat (3) @(negedge clk);
        chk({15'h0, irq_n}, 16'h0001);
        rd_chk(IRQ_ADDR, 16'h0000);
        i_host.wr(IRQ_ADDR, 16'h0002);
        pulse(1'b1, 1'b0);
        @(negedge clk);
        chk({15'h0, irq_n}, 16'h0000);
        rd_chk(IRQ_ADDR, 16'h0082);
        @(negedge clk);
        chk({15'h0, irq_n}, 16'h0001);
        chk({15'h0, rvalid}, 16'h0000);
        rd_chk(IRQ_ADDR, 16'h0002);
        // Sync error masked, then enabled
        i_host.wr(IRQ_ADDR, 16'h0000);
        pulse(1'b0, 1'b1);
        rd_chk(IRQ_ADDR, 16'h0000);
        i_host.wr(IRQ_ADDR, 16'h0001);
        pulse(1'b0, 1'b1);
        @(negedge clk);
        chk({15'h0, irq_n}, 16'h0000);
        rd_chk(IRQ_ADDR, 16'h0041);
        i_host.wr(IRQ_ADDR, 16'h0000);
        // Live lock state and latched loss
        evt.sync_locked = 1'b1;
        rd_chk(IRQ_ADDR, 16'h0400);
        evt.sync_locked = 1'b0;
        rd_chk(IRQ_ADDR, 16'h0800);
        evt.sync_locked = 1'b1;
        rd_chk(IRQ_ADDR, 16'h0C00);
        i_host.wr(IRQ_ADDR, 16'h1000);
        rd_chk(IRQ_ADDR, 16'h1400);
        // Host writes the clear bit back; status and reserved bits ignore the write
        i_host.wr(IRQ_ADDR, 16'hEFFC);
        evt.pll_locked = 1'b1;
        rd_chk(IRQ_ADDR, 16'h0408);
        // Setup type of both errors, captured in one cycle
        i_host.wr(IRQ_ADDR, 16'h0003);
        evt.data_setup = 1'b1;
        evt.sync_setup = 1'b1;
        pulse(1'b1, 1'b1);
        @(negedge clk);
        chk({15'h0, irq_n}, 16'h0000);
        rd_chk(IRQ_ADDR, 16'h04FB);
        conclude();
    end
endmodule
`default_nettype wire

// ===== dv/dtr_host.sv
// Serial control port host model issuing word reads and writes
`timescale 1ns/1ps
`default_nettype none
module dtr_host
    import dtr_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Register port
    output var  dtr_req_t          req,
    input  wire logic [DATA_W-1:0] rdata,
    input  wire logic              rvalid
);
    initial req = '0;

    // Idle port flips address and data so stale values never look valid
    task automatic idle();
        req.wr    = 1'b0;
        req.rd    = 1'b0;
        req.addr  = ~req.addr;
        req.wdata = ~req.wdata;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        idle();
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
        @(negedge clk);
        d = rdata;
        v = rvalid;
        idle();
    endtask
endmodule
`default_nettype wire

// ===== logic/dtr_bank.sv
// Converter trim registers and interrupt status bank on the serial port word interface
//
// Operation
// - Aux DAC one sign bit 15: 0 positive pin, 1 negative pin.
// - Aux DAC one bit 14: 0 sources current, 1 sinks current.
// - Aux DAC one bit 13 set powers that converter down.
// - Aux DAC one bits 9:0 carry its gain adjustment word.
// - Aux DAC two sign bit 15: 0 positive pin, 1 negative pin.
// - Aux DAC two bit 14: 0 sources current, 1 sinks current.
// - Aux DAC two bit 13 set powers that converter down.
// - Aux DAC two bits 9:0 carry its gain adjustment word.
// - Q channel bit 15 set puts the Q converter to sleep.
// - Q channel bit 14 set powers the Q converter down.
// - Q channel bits 9:0 carry the Q gain adjustment word.
// - Converter register contents go straight to the analog outputs.
// - Interrupt bits 11:10 and 7:3 come from logic and are read only.
// - Interrupt output goes low while an enabled event is pending.
// - Interrupt bits 1:0 are host-writable masks that read back.
// - Writing one to bit 12 clears lock lost; host writes it back.
// - Bit 11 latches loss of sync until the host clears it.
// - Bit 10 shows the live sync lock state, unlatched.
// - Bit 7 flags a data port setup or hold violation.
// - Bit 6 flags a sync pulse setup or hold violation.
// - Data port errors reach flag and interrupt only with mask bit 1 set.
// - Sync pulse errors reach flag and interrupt only with mask bit 0 set.
`timescale 1ns/1ps
`default_nettype none
module dtr_bank
    import dtr_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Serial port word access
    input  wire dtr_req_t          req,
    output var  logic [DATA_W-1:0] rdata,
    output var  logic              rvalid,
    // Event sources
    input  wire dtr_evt_t          evt,
    // Analog periphery controls
    output var  dtr_aux_t          aux1_ctl,
    output var  dtr_aux_t          aux2_ctl,
    output var  dtr_qch_t          qch_ctl,
    // Interrupt request
    output var  logic              irq_n
);
    logic [DATA_W-1:0] reg_q [NUM_REG];
    logic              lock_prev_reg;
    logic              lost_set;
    logic              lost_flag;
    logic              data_set;
    logic              data_flag;
    logic              sync_set;
    logic              sync_flag;
    logic              irq_rd;
    logic              dtype_reg;
    logic              stype_reg;
    logic              irq_n_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic              rvalid_reg;
    logic [DATA_W-1:0] status;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REG; gi++)
        begin : g_reg
            dtr_hold_reg #(
                .MASK (dtr_reg_mask(gi)),
                .RST  (REG_RST)
            ) u_reg (
                .clk   (clk),
                .rst_n (rst_n),
                .we    (req.wr && dtr_hit(req.addr, dtr_reg_addr(gi))),
                .wdata (req.wdata),
                .q     (reg_q[gi])
            );
        end
    endgenerate

    assign aux1_ctl = dtr_aux_t'({reg_q[0][SIGN_BIT:APD_BIT], reg_q[0][GAIN_W-1:0]});
    assign aux2_ctl = dtr_aux_t'({reg_q[2][SIGN_BIT:APD_BIT], reg_q[2][GAIN_W-1:0]});
    assign qch_ctl  = dtr_qch_t'({reg_q[1][SLEEP_BIT:QPD_BIT], reg_q[1][GAIN_W-1:0]});

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            lock_prev_reg <= 1'b0;
        else
            lock_prev_reg <= evt.sync_locked;
    end

    assign lost_set = lock_prev_reg && !evt.sync_locked;

    // stored clear bit holds flag clear, but a new loss in the same cycle still sets it
    dtr_sticky u_lost (
        .clk   (clk),
        .rst_n (rst_n),
        .set   (lost_set),
        .clr   (reg_q[3][CLR_BIT]),
        .q     (lost_flag)
    );

    assign data_set = evt.data_err && reg_q[3][DMASK_BIT];
    assign sync_set = evt.sync_err && reg_q[3][SMASK_BIT];
    // Error flags clear on a read of the interrupt register
    assign irq_rd   = req.rd && dtr_hit(req.addr, IRQ_ADDR);

    dtr_sticky u_data (
        .clk   (clk),
        .rst_n (rst_n),
        .set   (data_set),
        .clr   (irq_rd),
        .q     (data_flag)
    );

    dtr_sticky u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .set   (sync_set),
        .clr   (irq_rd),
        .q     (sync_flag)
    );

    // Error type follows the latest captured error
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dtype_reg <= 1'b0;
            stype_reg <= 1'b0;
        end
        else
        begin
            if (data_set)
                dtype_reg <= evt.data_setup;
            if (sync_set)
                stype_reg <= evt.sync_setup;
        end
    end

    // Lock loss has no mask bit, so it stays off the request line
    // active-low request from pending flags
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            irq_n_reg <= 1'b1;
        else
            irq_n_reg <= !(data_flag || sync_flag);
    end

    assign irq_n = irq_n_reg;

    // status bits built only from logic
    always_comb
    begin
        status            = '0;
        status[LOST_BIT]  = lost_flag;
        status[LOCK_BIT]  = evt.sync_locked;
        status[DERR_BIT]  = data_flag;
        status[SERR_BIT]  = sync_flag;
        status[DTYPE_BIT] = dtype_reg;
        status[STYPE_BIT] = stype_reg;
        status[PLL_BIT]   = evt.pll_locked;
    end

    // masks and clear bit read back
    always_comb
    begin
        rdata_next = '0;
        case (req.addr)
            AUX1_ADDR: rdata_next = reg_q[0];
            QCH_ADDR:  rdata_next = reg_q[1];
            AUX2_ADDR: rdata_next = reg_q[2];
            IRQ_ADDR:  rdata_next = reg_q[3] | status;
            default:   rdata_next = '0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= req.rd;
            if (req.rd)
                rdata_reg <= rdata_next;
        end
    end

    assign rdata  = rdata_reg;
    assign rvalid = rvalid_reg;

    // Helper state for the checks below
    logic [DATA_W-1:0] wdata_d;
    logic [ADDR_W-1:0] raddr_d;
    logic [1:0]        mask_d;
    always_ff @(posedge clk)
    begin
        wdata_d <= req.wdata;
        raddr_d <= req.addr;
    end

    // Own copy of the masks, so readback is not judged against itself
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            mask_d <= 2'h0;
        else if (req.wr && dtr_hit(req.addr, IRQ_ADDR))
            mask_d <= req.wdata[DMASK_BIT:SMASK_BIT];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_wr(logic [ADDR_W-1:0] a);
        req.wr && req.addr == a;
    endsequence

    sequence s_loss;
        evt.sync_locked ##1 !evt.sync_locked;
    endsequence

    a_aux1_fields: assert property (s_wr(AUX1_ADDR) |=> aux1_ctl.sign == wdata_d[SIGN_BIT]
        && aux1_ctl.sink == wdata_d[DIR_BIT] && aux1_ctl.pd == wdata_d[APD_BIT]
        && aux1_ctl.data == wdata_d[GAIN_W-1:0])
        else $error("aux one fields differ from write");
    a_aux2_fields: assert property (s_wr(AUX2_ADDR) |=> aux2_ctl.sign == wdata_d[SIGN_BIT]
        && aux2_ctl.sink == wdata_d[DIR_BIT] && aux2_ctl.pd == wdata_d[APD_BIT]
        && aux2_ctl.data == wdata_d[GAIN_W-1:0])
        else $error("aux two fields differ from write");
    a_qch_fields: assert property (s_wr(QCH_ADDR) |=> qch_ctl.sleep == wdata_d[SLEEP_BIT]
        && qch_ctl.pd == wdata_d[QPD_BIT] && qch_ctl.gain == wdata_d[GAIN_W-1:0])
        else $error("Q fields differ from write");
    a_out_stable: assert property (!req.wr |=> $stable(aux1_ctl) && $stable(aux2_ctl)
        && $stable(qch_ctl))
        else $error("converter output moved without write");
    a_status_ro: assert property (req.rd && req.addr == IRQ_ADDR
        |=> rdata[DATA_W-1:CLR_BIT+1] == '0 && rdata[9:8] == '0)
        else $error("reserved interrupt bits read nonzero");
    a_status_nowr: assert property (req.wr && req.addr == IRQ_ADDR && !irq_rd && !data_set && !sync_set
        |=> $stable(data_flag) && $stable(sync_flag))
        else $error("status flag moved by a write");
    a_irq_pend: assert property ((data_flag || sync_flag) |=> !irq_n)
        else $error("interrupt not asserted for pending flag");
    a_irq_idle: assert property (!data_flag && !sync_flag |=> irq_n)
        else $error("interrupt asserted with no flag");
    a_mask_rback: assert property (req.rd && req.addr == IRQ_ADDR && !req.wr
        |=> rdata[DMASK_BIT:SMASK_BIT] == mask_d)
        else $error("mask readback wrong");
    a_lost_clear: assert property (reg_q[3][CLR_BIT] && !lost_set |=> !lost_flag)
        else $error("lock lost not cleared");
    a_lost_latch: assert property (s_loss |=> lost_flag)
        else $error("loss of sync not latched");
    a_lost_hold: assert property (lost_flag && !reg_q[3][CLR_BIT] |=> lost_flag)
        else $error("lock lost dropped by itself");
    a_lock_live: assert property (req.rd && req.addr == IRQ_ADDR |=> rdata[LOCK_BIT] == $past(evt.sync_locked))
        else $error("lock state not live");
    a_data_flag: assert property (evt.data_err && reg_q[3][DMASK_BIT] |=> data_flag ##1 !irq_n)
        else $error("data error not flagged");
    a_sync_flag: assert property (evt.sync_err && reg_q[3][SMASK_BIT] |=> sync_flag ##1 !irq_n)
        else $error("sync error not flagged");
    a_data_mask: assert property (!data_flag && !reg_q[3][DMASK_BIT] |=> !data_flag)
        else $error("masked data error flagged");
    a_sync_mask: assert property (!sync_flag && !reg_q[3][SMASK_BIT] |=> !sync_flag)
        else $error("masked sync error flagged");
    a_rsv_read: assert property (rvalid && raddr_d == AUX1_ADDR |-> (rdata & ~AUX_WMASK) == '0)
        else $error("reserved bits read nonzero");
    a_rsv_qch: assert property (rvalid && raddr_d == QCH_ADDR |-> (rdata & ~QCH_WMASK) == '0)
        else $error("reserved Q bits read nonzero");
    a_rsv_aux2: assert property (rvalid && raddr_d == AUX2_ADDR |-> (rdata & ~AUX_WMASK) == '0)
        else $error("reserved aux two bits read nonzero");
    a_dtype_cap: assert property (data_set |=> dtype_reg == $past(evt.data_setup))
        else $error("data error type not captured");
    a_stype_cap: assert property (sync_set |=> stype_reg == $past(evt.sync_setup))
        else $error("sync error type not captured");
    a_flag_rdclr: assert property (irq_rd && !data_set && !sync_set |=> !data_flag && !sync_flag)
        else $error("error flags survive a status read");
endmodule
`default_nettype wire

// ===== logic/dtr_hold_reg.sv
// Host-written register with a write mask; masked bits stay zero
`timescale 1ns/1ps
`default_nettype none
module dtr_hold_reg
    import dtr_pkg::*;
#(
    parameter logic [DATA_W-1:0] MASK = 16'hFFFF,
    parameter logic [DATA_W-1:0] RST  = 16'h0000
)(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Write port
    input  wire logic              we,
    input  wire logic [DATA_W-1:0] wdata,
    // Stored value
    output var  logic [DATA_W-1:0] q
);
    logic [DATA_W-1:0] q_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            q_reg <= RST & MASK;
        else if (we)
            q_reg <= wdata & MASK;
    end

    assign q = q_reg;

    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) (q_reg & ~MASK) == '0)
        else $error("reserved bit stored as one");
endmodule
`default_nettype wire

// ===== logic/dtr_pkg.sv
// Package: register map, field layout and carriers of the DAC trim and IRQ status bank
package dtr_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int GAIN_W = 10;
    localparam int NUM_REG = 4;

    localparam logic [ADDR_W-1:0] AUX1_ADDR = 5'h06;
    localparam logic [ADDR_W-1:0] QCH_ADDR  = 5'h07;
    localparam logic [ADDR_W-1:0] AUX2_ADDR = 5'h08;
    localparam logic [ADDR_W-1:0] IRQ_ADDR  = 5'h09;

    // Writable bits; everything else is reserved and stored as zero
    localparam logic [DATA_W-1:0] AUX_WMASK = 16'hE3FF;
    localparam logic [DATA_W-1:0] QCH_WMASK = 16'hC3FF;
    localparam logic [DATA_W-1:0] IRQ_WMASK = 16'h1003;
    localparam logic [DATA_W-1:0] REG_RST   = 16'h0000;

    localparam int SIGN_BIT  = 15;
    localparam int DIR_BIT   = 14;
    localparam int APD_BIT   = 13;
    localparam int SLEEP_BIT = 15;
    localparam int QPD_BIT   = 14;
    localparam int CLR_BIT   = 12;
    localparam int LOST_BIT  = 11;
    localparam int LOCK_BIT  = 10;
    localparam int DERR_BIT  = 7;
    localparam int SERR_BIT  = 6;
    localparam int DTYPE_BIT = 5;
    localparam int STYPE_BIT = 4;
    localparam int PLL_BIT   = 3;
    localparam int DMASK_BIT = 1;
    localparam int SMASK_BIT = 0;

    // Host side of the serial port, one word per access
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dtr_req_t;

    // Status from the sync receiver, timing checkers and PLL
    typedef struct packed {
        logic sync_locked;
        logic data_err;
        logic data_setup;
        logic sync_err;
        logic sync_setup;
        logic pll_locked;
    } dtr_evt_t;

    typedef struct packed {
        logic              sign;
        logic              sink;
        logic              pd;
        logic [GAIN_W-1:0] data;
    } dtr_aux_t;

    typedef struct packed {
        logic              sleep;
        logic              pd;
        logic [GAIN_W-1:0] gain;
    } dtr_qch_t;

    function automatic logic dtr_hit(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] b);
        return a == b;
    endfunction

    function automatic logic [ADDR_W-1:0] dtr_reg_addr(int i);
        case (i)
            0:       return AUX1_ADDR;
            1:       return QCH_ADDR;
            2:       return AUX2_ADDR;
            default: return IRQ_ADDR;
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] dtr_reg_mask(int i);
        case (i)
            1:       return QCH_WMASK;
            3:       return IRQ_WMASK;
            default: return AUX_WMASK;
        endcase
    endfunction
endpackage

// ===== logic/dtr_sticky.sv
// Sticky event flag; a set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
module dtr_sticky (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Event and clear
    input  wire logic set,
    input  wire logic clr,
    // Flag
    output var  logic q
);
    logic q_reg;
    logic q_next;

    always_comb
    begin
        q_next = q_reg;
        if (set)
            q_next = 1'b1;
        else if (clr)
            q_next = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            q_reg <= 1'b0;
        else
            q_reg <= q_next;
    end

    assign q = q_reg;

    a_set_wins: assert property (@(posedge clk) disable iff (!rst_n) set |=> q_reg)
        else $error("event lost against clear");
endmodule
`default_nettype wire
